// ===== verilog/pcs_pkg.sv
package pcs_pkg;

    localparam int PC_W = 10;
    localparam int INSTR_W = 14;
    localparam int STACK_DEPTH = 6;
    localparam logic [9:0] RESET_VECTOR = 10'h3FF;
    localparam logic [9:0] IRQ_VECTOR = 10'h3FE;
    localparam logic [2:0] DIV4_LAST = 3'h3;
    localparam logic [2:0] DIV2_LAST = 3'h1;
    localparam logic [2:0] STACK_LAST = 3'h5;

    // Flow-control operations decoded by the core
    typedef enum logic [3:0] {
        PCS_OP_NEXT = 4'h0,
        PCS_OP_GOTO = 4'h1,
        PCS_OP_CALL = 4'h2,
        PCS_OP_RET = 4'h3,
        PCS_OP_SKIP = 4'h4,
        PCS_OP_PCWR = 4'h5
    } pcs_op_t;

    typedef struct packed {
        pcs_op_t op;
        logic [9:0] target;
        logic [7:0] pcl_wdata;
    } pcs_cmd_t;

    typedef struct packed {
        logic [9:0] addr;
        logic fetch;
    } pcs_fetch_t;

endpackage : pcs_pkg

// ===== verilog/pcs_stack.sv
`timescale 1ns/1ps
// Six-entry return stack; overflow wraps and overwrites oldest slot
module pcs_stack (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    input wire logic push_in,
    input wire logic pop_in,
    input wire logic [9:0] push_addr_in,
    output logic [9:0] top_out,
    output logic [2:0] depth_out
);

    logic [9:0] mem_q [pcs_pkg::STACK_DEPTH];
    logic [2:0] ptr_q;
    logic [2:0] depth_q;
    logic [2:0] ptr_inc;
    logic [2:0] ptr_dec;

    assign ptr_inc = (ptr_q == pcs_pkg::STACK_LAST) ? 3'h0 : ptr_q + 3'h1;
    assign ptr_dec = (ptr_q == 3'h0) ? pcs_pkg::STACK_LAST : ptr_q - 3'h1;
    assign top_out = mem_q[ptr_dec];
    assign depth_out = depth_q;

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ptr_q <= 3'h0;
            depth_q <= 3'h0;
        end else if (clear_in) begin
            // Pin reset empties the stack; slots keep their contents, so a return on an empty stack reads a stale slot
            ptr_q <= 3'h0;
            depth_q <= 3'h0;
        end else if (push_in) begin // RULE6
            ptr_q <= ptr_inc;
            if (depth_q != pcs_pkg::STACK_LAST + 3'h1) begin
                depth_q <= depth_q + 3'h1;
            end
        end else if (pop_in) begin
            ptr_q <= ptr_dec;
            if (depth_q != 3'h0) begin
                depth_q <= depth_q - 3'h1;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < pcs_pkg::STACK_DEPTH; g++) begin : g_slot
            always_ff @(posedge core_clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    mem_q[g] <= 10'h000;
                end else if (push_in && ptr_q == 3'(g)) begin
                    mem_q[g] <= push_addr_in;
                end
            end
        end
    endgenerate

endmodule : pcs_stack

// ===== verilog/pcs_sequencer.sv
`timescale 1ns/1ps
// What this block does
// (RULE1) 10-bit PC addresses 1K x 14 memory
// (RULE2) Reset loads PC with 3FFh
// (RULE3) Taken interrupt loads PC with 3FEh
// (RULE4) CALL and GOTO reach every address
// (RULE5) One cycle, two for flow changes
// (RULE6) Six-entry hardware return stack
// (RULE7) Instruction cycle is oscillator over four or two
// (RULE8) Low external reset restarts the device
// (RULE9) PC low byte readable and writable register
// (RULE10) Call or interrupt pushes, return pops
// (RULE11) Sequential fetch increments PC, wrapping
module pcs_sequencer (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic external_reset_n_in,
    input wire logic div2_sel_in,
    input wire pcs_pkg::pcs_cmd_t cmd_in,
    input wire logic irq_in,
    input wire logic [13:0] instr_in,
    output logic [9:0] pm_addr_out,
    output logic pm_fetch_out,
    output logic [13:0] instr_out,
    output logic instr_valid_out,
    output logic cycle_strobe_out,
    output logic irq_taken_out,
    output logic [7:0] pcl_out,
    output logic [2:0] stack_depth_out
);

    typedef enum logic [1:0] {
        PCS_ST_EXEC = 2'b01,
        PCS_ST_FLUSH = 2'b10
    } pcs_state_t;

    pcs_state_t state_q;
    pcs_state_t state_d;
    logic rst_meta_q;
    logic rst_sync_q;
    logic div_sel_meta_q;
    logic div_sel_q;
    logic [2:0] phase_q;
    logic [9:0] pc_q;
    logic [9:0] pc_d;
    logic [13:0] instr_q;
    logic valid_q;
    logic strobe_q;
    logic irq_taken_q;
    logic fetch_q;
    logic [7:0] pcl_q;
    logic [2:0] depth_q;
    logic [9:0] stack_top;
    logic [2:0] stack_depth;

    wire cycle_end = (phase_q == (div_sel_q ? pcs_pkg::DIV2_LAST : pcs_pkg::DIV4_LAST));
    wire in_exec = (state_q == PCS_ST_EXEC);
    wire irq_take = cycle_end && in_exec && irq_in;
    wire [9:0] pc_inc = pc_q + 10'h001; // RULE11
    // PC already points one past the word being executed
    wire [9:0] pc_dec = pc_q - 10'h001;
    wire stack_clear = !rst_sync_q;
    wire is_flow = (cmd_in.op == pcs_pkg::PCS_OP_GOTO) || (cmd_in.op == pcs_pkg::PCS_OP_CALL)
        || (cmd_in.op == pcs_pkg::PCS_OP_RET) || (cmd_in.op == pcs_pkg::PCS_OP_SKIP)
        || (cmd_in.op == pcs_pkg::PCS_OP_PCWR);
    wire exec_step = cycle_end && in_exec && !irq_in;
    wire do_push = irq_take
        || (exec_step && cmd_in.op == pcs_pkg::PCS_OP_CALL); // RULE10
    wire do_pop = exec_step && cmd_in.op == pcs_pkg::PCS_OP_RET; // RULE10
    // Interrupt preempts the latched word, so the return must re-run it
    wire [9:0] push_addr = irq_take ? pc_dec : pc_q; // RULE10

    function automatic logic [9:0] next_pc(
        input pcs_pkg::pcs_op_t op,
        input logic [9:0] pc,
        input logic [9:0] inc,
        input logic [9:0] target,
        input logic [9:0] top,
        input logic [7:0] low
    );
        case (op)
            pcs_pkg::PCS_OP_GOTO: next_pc = target; // RULE4
            pcs_pkg::PCS_OP_CALL: next_pc = target; // RULE4
            pcs_pkg::PCS_OP_RET: next_pc = top;
            // Flush cycle discards the prefetched word, which is the skip
            pcs_pkg::PCS_OP_SKIP: next_pc = inc;
            pcs_pkg::PCS_OP_PCWR: next_pc = {pc[9:8], low}; // RULE9
            default: next_pc = inc;
        endcase
    endfunction : next_pc

    // Flow changes spend a second cycle discarding the prefetched word
    always_comb begin
        state_d = state_q;
        pc_d = pc_q;
        case (state_q)
            PCS_ST_EXEC: begin
                if (irq_take) begin
                    pc_d = pcs_pkg::IRQ_VECTOR; // RULE3
                    state_d = PCS_ST_FLUSH;
                end else if (cycle_end) begin
                    pc_d = next_pc(cmd_in.op, pc_q, pc_inc, cmd_in.target, stack_top,
                        cmd_in.pcl_wdata);
                    state_d = is_flow ? PCS_ST_FLUSH : PCS_ST_EXEC; // RULE5
                end
            end
            PCS_ST_FLUSH: begin
                if (cycle_end) begin
                    pc_d = pc_inc;
                    state_d = PCS_ST_EXEC;
                end
            end
            default: begin
                state_d = PCS_ST_EXEC;
            end
        endcase
    end

    pcs_stack u_stack (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(stack_clear), // RULE8
        .push_in(do_push),
        .pop_in(do_pop),
        .push_addr_in(push_addr),
        .top_out(stack_top),
        .depth_out(stack_depth)
    );

    // Pin reset and option strap are asynchronous to the core clock
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
            div_sel_meta_q <= 1'b0;
            div_sel_q <= 1'b0;
        end else begin
            rst_meta_q <= external_reset_n_in;
            rst_sync_q <= rst_meta_q;
            div_sel_meta_q <= div2_sel_in;
            div_sel_q <= div_sel_meta_q;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_q <= 3'h0;
        end else if (!rst_sync_q || cycle_end) begin // RULE7
            phase_q <= 3'h0;
        end else begin
            phase_q <= phase_q + 3'h1;
        end
    end

    // Pin reset is held synchronous so the stack keeps its clock domain simple
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pc_q <= pcs_pkg::RESET_VECTOR; // RULE2
            state_q <= PCS_ST_FLUSH;
        end else if (!rst_sync_q) begin
            pc_q <= pcs_pkg::RESET_VECTOR; // RULE8
            state_q <= PCS_ST_FLUSH;
        end else begin
            pc_q <= pc_d; // RULE1
            state_q <= state_d;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            instr_q <= 14'h0000;
            valid_q <= 1'b0;
            strobe_q <= 1'b0;
            irq_taken_q <= 1'b0;
            fetch_q <= 1'b0;
            pcl_q <= 8'h00;
            depth_q <= 3'h0;
        end else begin
            strobe_q <= cycle_end && rst_sync_q;
            fetch_q <= rst_sync_q && (phase_q == 3'h0);
            irq_taken_q <= irq_take && rst_sync_q;
            if (!rst_sync_q) begin
                instr_q <= 14'h0000; // RULE8
                valid_q <= 1'b0;
            end else if (cycle_end) begin
                instr_q <= instr_in;
                // Word latched now runs next cycle, so judge by the next state
                valid_q <= (state_d == PCS_ST_EXEC); // RULE5
            end
            pcl_q <= pc_q[7:0]; // RULE9
            depth_q <= stack_depth;
        end
    end

    assign pm_addr_out = pc_q;
    assign pm_fetch_out = fetch_q;
    assign instr_out = instr_q;
    assign instr_valid_out = valid_q;
    assign cycle_strobe_out = strobe_q;
    assign irq_taken_out = irq_taken_q;
    assign pcl_out = pcl_q;
    assign stack_depth_out = depth_q;

endmodule : pcs_sequencer

// ===== testbench/pcs_sequencer_assertions.sv
`timescale 1ns/1ps
module pcs_sequencer_assertions (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic external_reset_n_in,
    input wire logic div2_sel_in,
    input wire logic cycle_strobe_out,
    input wire logic pm_fetch_out,
    input wire logic irq_taken_out,
    input wire logic instr_valid_out,
    input wire logic [13:0] instr_out,
    input wire logic [9:0] pm_addr_out,
    input wire logic [7:0] pcl_out,
    input wire logic [2:0] stack_depth_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in || !external_reset_n_in);
    sequence s_gap3;
        !cycle_strobe_out [*3] ##1 cycle_strobe_out;
    endsequence
    sequence s_gap1;
        !cycle_strobe_out ##1 cycle_strobe_out;
    endsequence
    property p_reset_vec;
        $rose(rst_n_in) |-> pm_addr_out == 10'h3FF;
    endproperty
    property p_div4;
        cycle_strobe_out && !div2_sel_in |=> s_gap3;
    endproperty
    property p_div2;
        cycle_strobe_out && div2_sel_in |=> s_gap1;
    endproperty
    property p_pc_moves;
        $changed(pm_addr_out) |-> cycle_strobe_out;
    endproperty
    property p_irq_vec;
        irq_taken_out |-> pm_addr_out == 10'h3FE;
    endproperty
    property p_pcl;
        $past(rst_n_in) |-> pcl_out == $past(pm_addr_out[7:0]);
    endproperty
    property p_depth;
        stack_depth_out <= 3'h6;
    endproperty
    property p_fetch;
        cycle_strobe_out |=> pm_fetch_out;
    endproperty
    property p_stands;
        !cycle_strobe_out |-> $stable(instr_out) && $stable(instr_valid_out);
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("PC not at start vector");
    a_div4: assert property (p_div4) else $error("Cycle not four clocks");
    a_div2: assert property (p_div2) else $error("Cycle not two clocks");
    a_pc_moves: assert property (p_pc_moves) else $error("PC moved mid cycle");
    a_irq_vec: assert property (p_irq_vec) else $error("Interrupt vector wrong");
    a_pcl: assert property (p_pcl) else $error("PC low byte wrong");
    a_depth: assert property (p_depth) else $error("Stack depth above six");
    a_stands: assert property (p_stands) else $error("Instruction changed mid cycle");
    a_fetch: assert property (p_fetch) else $error("No fetch after cycle start");
endmodule : pcs_sequencer_assertions
bind pcs_sequencer pcs_sequencer_assertions pcs_sequencer_assertions_inst (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .external_reset_n_in(external_reset_n_in),
    .div2_sel_in(div2_sel_in), .cycle_strobe_out(cycle_strobe_out),
    .pm_fetch_out(pm_fetch_out),
    .irq_taken_out(irq_taken_out), .instr_valid_out(instr_valid_out), .instr_out(instr_out),
    .pm_addr_out(pm_addr_out), .pcl_out(pcl_out), .stack_depth_out(stack_depth_out));

// ===== testbench/pcs_prog_mem.sv
`timescale 1ns/1ps
module pcs_prog_mem (
    input wire logic [9:0] addr_in,
    output logic [13:0] data_out
);
    // Each word carries its own address, so fetch order shows
    assign data_out = {4'hA, addr_in};
endmodule : pcs_prog_mem

// ===== testbench/program_counter_sequencer_test.sv
`timescale 1ns/1ps
module program_counter_sequencer_test;
    logic clk = 1'b0, rst_n = 1'b0, ext_n = 1'b1, div2 = 1'b0, irq = 1'b0;
    pcs_pkg::pcs_cmd_t cmd = '0;
    logic [13:0] word, instr;
    logic [9:0] pm;
    logic valid, strobe, taken;
    logic [2:0] depth;
    logic [7:0] pcl;
    int fails = 0, checks_done = 0, gap = 0;
    pcs_sequencer pcs_sequencer_inst (.core_clk_in(clk), .rst_n_in(rst_n),
        .external_reset_n_in(ext_n), .div2_sel_in(div2), .cmd_in(cmd), .irq_in(irq),
        .instr_in(word), .pm_addr_out(pm), .pm_fetch_out(), .instr_out(instr),
        .instr_valid_out(valid), .cycle_strobe_out(strobe), .irq_taken_out(taken),
        .pcl_out(pcl), .stack_depth_out(depth));
    pcs_prog_mem pcs_prog_mem_inst (.addr_in(pm), .data_out(word));
    initial forever #5 clk = ~clk;
    task check(input logic [13:0] seen, input logic [13:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task chk_pc(input logic [9:0] exp);
        check({4'h0, pm}, {4'h0, exp});
    endtask : chk_pc
    task end_of_test;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    // Sampled at negedge so flow commands land well before the cycle's last edge
    task wait_strobe;
        gap = 0;
        do begin
            @(negedge clk);
            gap++;
        end while (strobe !== 1'b1 && gap < 40);
        if (gap >= 40) fails++;
    endtask : wait_strobe
    task step(input pcs_pkg::pcs_op_t op, input logic [9:0] tgt, input logic [7:0] low = 8'h00);
        @(posedge clk) cmd <= '{op, tgt, low};
        wait_strobe();
    endtask : step
    task do_reset(input logic d2);
        @(posedge clk) rst_n <= 1'b0;
        div2 <= d2;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
    endtask : do_reset
    task t_start;
        do_reset(1'b0);
        @(negedge clk) chk_pc(10'h3FF);
        repeat (4) if (valid !== 1'b1) step(pcs_pkg::PCS_OP_NEXT, 10'h000);
        check(instr, 14'h2BFF);
        chk_pc(10'h000);
        step(pcs_pkg::PCS_OP_NEXT, 10'h000);
        check(instr, 14'h2800);
        chk_pc(10'h001);
    endtask : t_start
    task t_goto;
        step(pcs_pkg::PCS_OP_GOTO, 10'h3FD);
        check({13'h0, valid}, 14'h0000);
        chk_pc(10'h3FD);
        step(pcs_pkg::PCS_OP_NEXT, 10'h000);
        check(instr, 14'h2BFD);
        repeat (2) step(pcs_pkg::PCS_OP_NEXT, 10'h000);
        chk_pc(10'h000);
    endtask : t_goto
    task t_flow;
        step(pcs_pkg::PCS_OP_SKIP, 10'h000);
        check({13'h0, valid}, 14'h0000);
        chk_pc(10'h001);
        step(pcs_pkg::PCS_OP_NEXT, 10'h000);
        check(instr, 14'h2801);
        step(pcs_pkg::PCS_OP_PCWR, 10'h000, 8'h55);
        chk_pc(10'h055);
        @(negedge clk);
        check({6'h0, pcl}, 14'h0055);
        step(pcs_pkg::PCS_OP_NEXT, 10'h000);
        check(instr, 14'h2855);
    endtask : t_flow
    task t_stack;
        for (int i = 0; i < 7; i++) begin
            step(pcs_pkg::PCS_OP_CALL, 10'h100 + 10'(i));
            step(pcs_pkg::PCS_OP_NEXT, 10'h000);
        end
        check({11'h0, depth}, 14'h0006);
        step(pcs_pkg::PCS_OP_RET, 10'h000);
        chk_pc(10'h106);
        step(pcs_pkg::PCS_OP_NEXT, 10'h000);
        check({11'h0, depth}, 14'h0005);
    endtask : t_stack
    task t_irq;
        @(posedge clk) irq <= 1'b1;
        repeat (40) if (taken !== 1'b1) @(negedge clk);
        @(posedge clk) irq <= 1'b0;
        @(negedge clk) chk_pc(10'h3FE);
        repeat (2) wait_strobe();
        check({11'h0, depth}, 14'h0006);
        step(pcs_pkg::PCS_OP_RET, 10'h000);
        chk_pc(10'h106);
        step(pcs_pkg::PCS_OP_NEXT, 10'h000);
        check({11'h0, depth}, 14'h0005);
    endtask : t_irq
    task t_pin;
        @(posedge clk) ext_n <= 1'b0;
        repeat (5) @(posedge clk);
        ext_n <= 1'b1;
        @(negedge clk) chk_pc(10'h3FF);
        check({11'h0, depth}, 14'h0000);
        check({13'h0, valid}, 14'h0000);
    endtask : t_pin
    task t_rate(input logic d2, input int exp);
        do_reset(d2);
        repeat (3) wait_strobe();
        check(14'(gap), 14'(exp));
    endtask : t_rate
    initial begin
        t_start();
        t_goto();
        t_flow();
        t_stack();
        t_irq();
        t_pin();
        t_rate(1'b1, 2);
        t_rate(1'b0, 4);
        end_of_test();
    end
    // Whole run needs a few hundred clocks
    initial begin
        #200000;
        fails++;
        end_of_test();
    end
endmodule : program_counter_sequencer_test
